// File: prs_defs.svh
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// Program counter and stack geometry.
`define PRS_PC_RST        21'h0_0000
`define PRS_VEC_HIGH      21'h0_0008
`define PRS_VEC_LOW       21'h0_0018
`define PRS_PC_STEP       21'h0_0002
`define PRS_PROG_MEM_END  21'h0_6000
`define PRS_SP_RST        5'h00
`define PRS_SP_ONE        5'h01
`define PRS_SP_TOP        5'h1f

// Register byte addresses on the bus.
`define PRS_ADDR_RETURN_STACK_POINTER_STATUS   8'h00
`define PRS_ADDR_TOS_UP   8'h04
`define PRS_ADDR_TOS_HI   8'h08
`define PRS_ADDR_TOS_LO   8'h0c
`define PRS_ADDR_PC_LO    8'h10
`define PRS_ADDR_LAT_HI   8'h14
`define PRS_ADDR_LAT_UP   8'h18
`define PRS_ADDR_CONFIG   8'h1c

// Field positions and reset values.
`define PRS_FULL_BIT      7
`define PRS_UNF_BIT       6
`define PRS_FAULT_EN_RST  1'b1
`define PRS_LAT_RST       8'h00

// Bus responses.
`define PRS_RESP_OKAY     2'h0
`define PRS_RESP_SLVERR   2'h2

`endif

// File: prs_pkg.sv
package prs_pkg;

	// Operations requested by the instruction sequencer.
	typedef enum logic [3:0] {
		PRS_OP_SEQ    = 4'h0,
		PRS_OP_GOTO   = 4'h1,
		PRS_OP_BRANCH = 4'h2,
		PRS_OP_CALL   = 4'h3,
		PRS_OP_RELATIVE_CALL  = 4'h4,
		PRS_OP_INTR   = 4'h5,
		PRS_OP_RETURN = 4'h6,
		PRS_OP_RETURN_WITH_LITERAL  = 4'h7,
		PRS_OP_RETURN_FROM_INTERRUPT = 4'h8,
		PRS_OP_PUSH   = 4'h9,
		PRS_OP_POP    = 4'ha
	} prs_op_t;

	// One sequencer command, sampled when valid is high.
	typedef struct packed {
		logic        valid;
		prs_op_t     op;
		logic [20:0] target;
		logic        high_prio;
		logic        fast;
	} prs_cmd_t;

	// Registers kept by the single-level shadow.
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] working_register;
		logic [7:0] bank_select_register;
	} prs_shadow_t;

endpackage

// File: prs_stack_unit.sv
`timescale 1ns/1ps
`include "prs_defs.svh"

module prs_stack_unit (
	// Clock and reset.
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// Non power-on resets from the core.
	input  wire logic                 core_reset,
	// AXI4-Lite write address channel.
	input  wire logic [7:0]           awaddr,
	input  wire logic [2:0]           awprot,
	input  wire logic                 awvalid,
	output logic                      awready,
	// AXI4-Lite write data channel.
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	// AXI4-Lite write response channel.
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	// AXI4-Lite read address channel.
	input  wire logic [7:0]           araddr,
	input  wire logic [2:0]           arprot,
	input  wire logic                 arvalid,
	output logic                      arready,
	// AXI4-Lite read data channel.
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	// Sequencer side.
	input  wire prs_pkg::prs_cmd_t    cmd,
	input  wire prs_pkg::prs_shadow_t live_regs,
	input  wire logic [15:0]          prog_word,
	output logic [20:0]               prog_addr,
	output logic [15:0]               fetch_word,
	output logic                      stack_fault_reset,
	output logic                      restore_valid,
	output prs_pkg::prs_shadow_t      restore_regs
);

	////////////////////////////////////////////////////////////////////////////
	// Storage.

	logic [20:0]          pc_r;
	logic [4:0]           sp_r;
	logic                 full_r;
	logic                 unf_r;
	logic                 fault_en_r;
	logic [7:0]           lat_hi_r;
	logic [4:0]           lat_up_r;
	logic [20:0]          stack_r [1:31];
	prs_pkg::prs_shadow_t shadow_r;
	logic [15:0]          fetch_r;
	logic                 fault_rst_r;
	logic                 restore_valid_r;
	prs_pkg::prs_shadow_t restore_r;

	// Bus channel state.
	logic                 awready_r;
	logic                 wready_r;
	logic                 bvalid_r;
	logic [1:0]           bresp_r;
	logic                 arready_r;
	logic                 rvalid_r;
	logic [31:0]          rdata_r;
	logic [1:0]           rresp_r;
	logic [7:0]           wr_addr_r;
	logic [31:0]          wr_data_r;
	logic [3:0]           wr_strb_r;
	logic                 aw_have_r;
	logic                 w_have_r;

	// Forces a target address onto an instruction boundary.
	function automatic logic [20:0] pc_align(input logic [20:0] addr);
		pc_align = {addr[20:1], 1'b0};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Sequencer decode.

	logic        op_fire;
	logic        is_push;
	logic        is_pop;
	logic [20:0] tos_val;
	logic [20:0] pc_nxt;
	logic [4:0]  sp_nxt;
	logic        st_wr;
	logic [20:0] st_val;
	logic        full_set;
	logic        unf_set;
	logic        fault_rst;
	logic        soft_rst;

	assign op_fire  = cmd.valid;
	assign is_push  = (cmd.op == prs_pkg::PRS_OP_CALL) || (cmd.op == prs_pkg::PRS_OP_RELATIVE_CALL) ||
	                  (cmd.op == prs_pkg::PRS_OP_INTR) || (cmd.op == prs_pkg::PRS_OP_PUSH);
	assign is_pop   = (cmd.op == prs_pkg::PRS_OP_RETURN) || (cmd.op == prs_pkg::PRS_OP_RETURN_WITH_LITERAL) ||
	                  (cmd.op == prs_pkg::PRS_OP_RETURN_FROM_INTERRUPT) || (cmd.op == prs_pkg::PRS_OP_POP);
	// Pointer value zero has no storage behind it and reads as zero.
	assign tos_val  = (sp_r == `PRS_SP_RST) ? `PRS_PC_RST : stack_r[sp_r];
	assign soft_rst = core_reset || fault_rst_r;

	// Computes the counter, pointer and stack effects of one command.
	always_comb begin
		pc_nxt    = pc_r;
		sp_nxt    = sp_r;
		st_wr     = 1'b0;
		st_val    = pc_r;
		full_set  = 1'b0;
		unf_set   = 1'b0;
		fault_rst = 1'b0;
		if (op_fire && is_push) begin
			if (sp_r != `PRS_SP_TOP) begin
				sp_nxt = 5'(sp_r + `PRS_SP_ONE);
				st_wr  = 1'b1;
				if (sp_nxt == `PRS_SP_TOP) begin
					full_set = 1'b1;
					if (fault_en_r) begin
						st_val    = pc_r + `PRS_PC_STEP;
						fault_rst = 1'b1;
					end
				end
			end
		end
		if (op_fire && is_pop) begin
			if (sp_r == `PRS_SP_RST) begin
				unf_set   = 1'b1;
				fault_rst = fault_en_r;
			end else begin
				sp_nxt = 5'(sp_r - `PRS_SP_ONE);
			end
		end
		if (op_fire) begin
			case (cmd.op)
				prs_pkg::PRS_OP_SEQ: begin
					pc_nxt = pc_align(pc_r + `PRS_PC_STEP);
				end
				prs_pkg::PRS_OP_GOTO, prs_pkg::PRS_OP_BRANCH, prs_pkg::PRS_OP_CALL, prs_pkg::PRS_OP_RELATIVE_CALL: begin
					pc_nxt = pc_align(cmd.target);
				end
				prs_pkg::PRS_OP_INTR: begin
					pc_nxt = cmd.high_prio ? `PRS_VEC_HIGH : `PRS_VEC_LOW;
				end
				prs_pkg::PRS_OP_RETURN, prs_pkg::PRS_OP_RETURN_WITH_LITERAL, prs_pkg::PRS_OP_RETURN_FROM_INTERRUPT: begin
					pc_nxt = pc_align(tos_val);
				end
				default: begin
					pc_nxt = pc_r;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic       aw_fire;
	logic       w_fire;
	logic       ar_fire;
	logic       wr_fire;
	logic       wr_lane;
	logic [7:0] wr_byte;
	logic       wr_sp;
	logic       wr_tos_up;
	logic       wr_tos_hi;
	logic       wr_tos_lo;
	logic       wr_pcl;
	logic       wr_lat_hi;
	logic       wr_lat_up;
	logic       wr_cfg;
	logic       wr_mapped;
	logic       rd_pcl;

	assign aw_fire   = awvalid && awready_r;
	assign w_fire    = wvalid && wready_r;
	assign ar_fire   = arvalid && arready_r;
	// A register write waits while the sequencer issues a command.
	assign wr_fire   = aw_have_r && w_have_r && !bvalid_r && !op_fire;
	assign wr_lane   = wr_fire && wr_strb_r[0];
	assign wr_byte   = wr_data_r[7:0];
	assign wr_sp     = wr_lane && (wr_addr_r == `PRS_ADDR_RETURN_STACK_POINTER_STATUS);
	assign wr_tos_up = wr_lane && (wr_addr_r == `PRS_ADDR_TOS_UP) && (sp_r != `PRS_SP_RST);
	assign wr_tos_hi = wr_lane && (wr_addr_r == `PRS_ADDR_TOS_HI) && (sp_r != `PRS_SP_RST);
	assign wr_tos_lo = wr_lane && (wr_addr_r == `PRS_ADDR_TOS_LO) && (sp_r != `PRS_SP_RST);
	assign wr_pcl    = wr_lane && (wr_addr_r == `PRS_ADDR_PC_LO);
	assign wr_lat_hi = wr_lane && (wr_addr_r == `PRS_ADDR_LAT_HI);
	assign wr_lat_up = wr_lane && (wr_addr_r == `PRS_ADDR_LAT_UP);
	assign wr_cfg    = wr_lane && (wr_addr_r == `PRS_ADDR_CONFIG);
	assign wr_mapped = (wr_addr_r[7:5] == 3'h0) && (wr_addr_r[1:0] == 2'h0);
	assign rd_pcl    = ar_fire && (araddr == `PRS_ADDR_PC_LO);

	////////////////////////////////////////////////////////////////////////////
	// Program counter.

	// Commands win over a low byte write; a write loads all 21 bits at once.
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst || fault_rst) begin
			pc_r <= `PRS_PC_RST;
		end else if (op_fire) begin
			pc_r <= pc_nxt;
		end else if (wr_pcl) begin
			pc_r <= {lat_up_r, lat_hi_r, wr_byte[7:1], 1'b0};
		end
	end

	// Latches change only by bus access, never by calls or returns.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lat_hi_r <= `PRS_LAT_RST;
			lat_up_r <= 5'h00;
		end else if (wr_lat_hi || wr_lat_up) begin
			if (wr_lat_hi) begin
				lat_hi_r <= wr_byte;
			end
			if (wr_lat_up) begin
				lat_up_r <= wr_byte[4:0];
			end
		end else if (rd_pcl) begin
			lat_hi_r <= pc_r[15:8];
			lat_up_r <= pc_r[20:16];
		end
	end

	// Registers the word fetched at the counter, zero beyond memory.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch_r <= 16'h0000;
		end else if (pc_r >= `PRS_PROG_MEM_END) begin
			fetch_r <= 16'h0000;
		end else begin
			fetch_r <= prog_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Return stack.

	// Pointer: cleared by every reset, moved by commands or software.
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst || fault_rst) begin
			sp_r <= `PRS_SP_RST;
		end else if (op_fire) begin
			sp_r <= sp_nxt;
		end else if (wr_sp) begin
			sp_r <= wr_byte[4:0];
		end
	end

	// Stack entries: pushes store the counter (plus one step on a fault reset overflow), software edits the top.
	always_ff @(posedge aclk) begin
		if (st_wr) begin
			stack_r[sp_nxt] <= st_val;
		end else if (wr_tos_up) begin
			stack_r[sp_r][20:16] <= wr_byte[4:0];
		end else if (wr_tos_hi) begin
			stack_r[sp_r][15:8] <= wr_byte;
		end else if (wr_tos_lo) begin
			stack_r[sp_r][7:0] <= wr_byte;
		end
	end

	// Fault flags: only power-on or software clear them; a set wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			full_r <= 1'b0;
			unf_r  <= 1'b0;
		end else begin
			full_r <= full_set || (full_r && !(wr_sp && !wr_byte[`PRS_FULL_BIT]));
			unf_r  <= unf_set || (unf_r && !(wr_sp && !wr_byte[`PRS_UNF_BIT]));
		end
	end

	// Stack fault reset enable and the one-cycle reset request.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_en_r  <= `PRS_FAULT_EN_RST;
			fault_rst_r <= 1'b0;
		end else begin
			fault_rst_r <= fault_rst;
			if (wr_cfg) begin
				fault_en_r <= wr_byte[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fast register shadow.

	// Captured on interrupt entry, returned by a fast interrupt return.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shadow_r        <= '0;
			restore_r       <= '0;
			restore_valid_r <= 1'b0;
		end else begin
			restore_valid_r <= 1'b0;
			if (op_fire && (cmd.op == prs_pkg::PRS_OP_INTR)) begin
				shadow_r <= live_regs;
			end
			if (op_fire && (cmd.op == prs_pkg::PRS_OP_RETURN_FROM_INTERRUPT) && cmd.fast) begin
				restore_r       <= shadow_r;
				restore_valid_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path.

	// Address and data are taken independently and held until the write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 32'h0000_0000;
			wr_strb_r <= 4'h0;
		end else begin
			if (aw_fire) begin
				awready_r <= 1'b0;
				aw_have_r <= 1'b1;
				wr_addr_r <= awaddr;
			end
			if (w_fire) begin
				wready_r  <= 1'b0;
				w_have_r  <= 1'b1;
				wr_data_r <= wdata;
				wr_strb_r <= wstrb;
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
			end
			if (bvalid_r && bready) begin
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Write response, an error for addresses outside the map.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `PRS_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_mapped ? `PRS_RESP_OKAY : `PRS_RESP_SLVERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path.

	logic [7:0] rd_byte;
	logic       rd_mapped;

	// Read data selection; the shadow has no address at all.
	always_comb begin
		rd_mapped = 1'b1;
		case (araddr)
			`PRS_ADDR_RETURN_STACK_POINTER_STATUS: rd_byte = {full_r, unf_r, 1'b0, sp_r};
			`PRS_ADDR_TOS_UP: rd_byte = {3'h0, tos_val[20:16]};
			`PRS_ADDR_TOS_HI: rd_byte = tos_val[15:8];
			`PRS_ADDR_TOS_LO: rd_byte = tos_val[7:0];
			`PRS_ADDR_PC_LO:  rd_byte = pc_r[7:0];
			`PRS_ADDR_LAT_HI: rd_byte = lat_hi_r;
			`PRS_ADDR_LAT_UP: rd_byte = {3'h0, lat_up_r};
			`PRS_ADDR_CONFIG: rd_byte = {7'h00, fault_en_r};
			default: begin
				rd_byte   = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
	end

	// One read at a time; data follows the address by one cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= `PRS_RESP_OKAY;
		end else if (ar_fire) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= {24'h00_0000, rd_byte};
			rresp_r   <= rd_mapped ? `PRS_RESP_OKAY : `PRS_RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from a flip-flop.

	assign awready           = awready_r;
	assign wready            = wready_r;
	assign bvalid            = bvalid_r;
	assign bresp             = bresp_r;
	assign arready           = arready_r;
	assign rvalid            = rvalid_r;
	assign rdata             = rdata_r;
	assign rresp             = rresp_r;
	assign prog_addr         = pc_r;
	assign fetch_word        = fetch_r;
	assign stack_fault_reset = fault_rst_r;
	assign restore_valid     = restore_valid_r;
	assign restore_regs      = restore_r;

endmodule

// File: prs_mem_model.sv
`timescale 1ns/1ps

module prs_mem_model (
	// Fetch address from the counter.
	input  wire logic [20:0] prog_addr,
	// Word stored at that address.
	output logic      [15:0] prog_word
);
	// Every word differs from its neighbours, and the region past the end is not blank, so the block must blank it.
	assign prog_word = prog_addr[16:1] ^ 16'hc3a5;
endmodule

// File: prs_stack_unit_chk.sv
`timescale 1ns/1ps
`include "prs_defs.svh"

module prs_stack_unit_chk (
	// Clock and reset.
	input wire logic              aclk,
	input wire logic              aresetn,
	// Watched ports.
	input wire logic              core_reset,
	input wire prs_pkg::prs_cmd_t cmd,
	input wire logic [15:0]       prog_word,
	input wire logic [20:0]       prog_addr,
	input wire logic [15:0]       fetch_word,
	input wire logic              stack_fault_reset,
	input wire logic              restore_valid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	// Counter movement.
	pc_align_a: assert property (prog_addr[0] == 1'b0)
		else $error("counter bit zero set");
	seq_step_a: assert property (cmd.valid && cmd.op == prs_pkg::PRS_OP_SEQ && !core_reset
		|=> prog_addr == $past(prog_addr) + `PRS_PC_STEP) else $error("sequential step wrong");
	jump_load_a: assert property (cmd.valid && !core_reset &&
		(cmd.op == prs_pkg::PRS_OP_GOTO || cmd.op == prs_pkg::PRS_OP_BRANCH)
		|=> prog_addr == {$past(cmd.target[20:1]), 1'b0}) else $error("jump target wrong");
	intr_vector_a: assert property (cmd.valid && cmd.op == prs_pkg::PRS_OP_INTR && !core_reset
		|=> stack_fault_reset || prog_addr == ($past(cmd.high_prio) ? `PRS_VEC_HIGH : `PRS_VEC_LOW))
		else $error("interrupt vector wrong");
	core_clear_a: assert property (core_reset && !cmd.valid |=> prog_addr == `PRS_PC_RST)
		else $error("core reset left counter");

	////////////////////////////////////////////////////////////////////////
	// Stack faults, fetch and shadow.
	fault_pc_a: assert property (stack_fault_reset |-> prog_addr == `PRS_PC_RST)
		else $error("fault reset left counter");
	fault_pulse_a: assert property (stack_fault_reset |=> !stack_fault_reset)
		else $error("fault request too long");
	fetch_blank_a: assert property (prog_addr >= `PRS_PROG_MEM_END |=> fetch_word == 16'h0000)
		else $error("fetch past end not blank");
	fetch_pass_a: assert property (prog_addr < `PRS_PROG_MEM_END |=> fetch_word == $past(prog_word))
		else $error("fetch word wrong");
	restore_pulse_a: assert property (cmd.valid && cmd.op == prs_pkg::PRS_OP_RETURN_FROM_INTERRUPT && cmd.fast
		&& !core_reset |=> restore_valid) else $error("fast return without restore");
	restore_only_fast_a: assert property (!(cmd.valid && cmd.op == prs_pkg::PRS_OP_RETURN_FROM_INTERRUPT && cmd.fast)
		|=> !restore_valid) else $error("restore without fast return");
endmodule

bind prs_stack_unit prs_stack_unit_chk u_chk (.aclk, .aresetn, .core_reset, .cmd, .prog_word, .prog_addr,
	.fetch_word, .stack_fault_reset, .restore_valid);

// File: program_counter_return_stack_tb.sv
`timescale 1ns/1ps
`include "prs_defs.svh"

module program_counter_return_stack_tb;
	logic                 aclk, aresetn, core_reset;
	logic [7:0]           awaddr, araddr, mlh;
	logic [31:0]          wdata, rdata;
	logic                 awvalid, awready, wvalid, wready, bvalid, bready;
	logic                 arvalid, arready, rvalid, rready, stack_fault_reset, restore_valid;
	logic [1:0]           bresp, rresp;
	prs_pkg::prs_cmd_t    cmd;
	prs_pkg::prs_shadow_t live_regs, restore_regs, msh;
	logic [15:0]          prog_word, fetch_word;
	logic [20:0]          prog_addr, mpc;
	logic [20:0]          stk [32];
	logic [4:0]           mp, mlu;
	logic                 mfull, munf, men, mflt;
	int                   num_errors, check_count, seed, i;

	prs_stack_unit dut (.aclk, .aresetn, .core_reset, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
		.wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .cmd, .live_regs, .prog_word, .prog_addr, .fetch_word,
		.stack_fault_reset, .restore_valid, .restore_regs);
	prs_mem_model mem (.prog_addr, .prog_word);

	////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and model helpers.
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	function automatic logic [20:0] rnd();
		logic [31:0] r;
		r = $random(seed);
		return r[20:0];
	endfunction

	function automatic logic [7:0] mrd(logic [7:0] a);
		logic [20:0] t;
		t = (mp == 5'h00) ? 21'h0_0000 : stk[mp];
		case (a)
			`PRS_ADDR_RETURN_STACK_POINTER_STATUS: return {mfull, munf, 1'b0, mp};
			`PRS_ADDR_TOS_UP: return {3'h0, t[20:16]};
			`PRS_ADDR_TOS_HI: return t[15:8];
			`PRS_ADDR_TOS_LO: return t[7:0];
			`PRS_ADDR_PC_LO: return mpc[7:0];
			`PRS_ADDR_LAT_HI: return mlh;
			`PRS_ADDR_LAT_UP: return {3'h0, mlu};
			`PRS_ADDR_CONFIG: return {7'h00, men};
			default: return 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register bus master; each channel is held until its ready.
	task automatic reg_r(logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 40);
		rready <= 1'b0;
		if (rvalid !== 1'b1) num_errors++;
		chk("rdata", {24'h0, mrd(a)}, rdata);
		chk("rresp", (a <= 8'h1c && a[1:0] == 2'h0) ? `PRS_RESP_OKAY : `PRS_RESP_SLVERR, rresp);
		if (a == `PRS_ADDR_PC_LO) begin
			mlu = mpc[20:16];
			mlh = mpc[15:8];
		end
	endtask

	task automatic reg_w(logic [7:0] a, logic [7:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 40);
		bready <= 1'b0;
		if (bvalid !== 1'b1) num_errors++;
		chk("bresp", `PRS_RESP_OKAY, bresp);
		case (a)
			`PRS_ADDR_RETURN_STACK_POINTER_STATUS: begin
				mfull = mfull & d[7];
				munf = munf & d[6];
				mp = d[4:0];
			end
			`PRS_ADDR_TOS_UP: stk[mp][20:16] = d[4:0];
			`PRS_ADDR_TOS_HI: stk[mp][15:8] = d;
			`PRS_ADDR_TOS_LO: stk[mp][7:0] = d;
			`PRS_ADDR_PC_LO: mpc = {mlu, mlh, d[7:1], 1'b0};
			`PRS_ADDR_LAT_HI: mlh = d;
			`PRS_ADDR_LAT_UP: mlu = d[4:0];
			default: men = d[0];
		endcase
	endtask

	////////////////////////////////////////////////////////////////////////
	// One sequencer command; target bit 2 picks priority, bit 3 the fast return.
	task automatic op(prs_pkg::prs_op_t o, logic [20:0] t);
		logic [20:0] old;
		logic [31:0] r;
		old = mpc;
		mflt = 1'b0;
		r = $random(seed);
		@(posedge aclk);
		cmd <= '{1'b1, o, t, t[2], t[3]};
		live_regs <= r[23:0];
		case (o)
			prs_pkg::PRS_OP_SEQ: mpc = old + `PRS_PC_STEP;
			prs_pkg::PRS_OP_GOTO, prs_pkg::PRS_OP_BRANCH: mpc = {t[20:1], 1'b0};
			prs_pkg::PRS_OP_RETURN, prs_pkg::PRS_OP_RETURN_WITH_LITERAL, prs_pkg::PRS_OP_RETURN_FROM_INTERRUPT, prs_pkg::PRS_OP_POP: begin
				if (mp == 5'h00) begin
					munf = 1'b1;
					mflt = men;
					if (o != prs_pkg::PRS_OP_POP) mpc = 21'h0_0000;
				end else begin
					if (o != prs_pkg::PRS_OP_POP) mpc = stk[mp];
					mp = mp - 5'h01;
				end
			end
			default: begin
				if (mp == 5'h1e && men) begin
					stk[31] = old + `PRS_PC_STEP;
					mfull = 1'b1;
					mflt = 1'b1;
				end else if (mp != 5'h1f) begin
					mp = mp + 5'h01;
					stk[mp] = old;
					mfull = mfull | (mp == 5'h1f);
				end
				if (o == prs_pkg::PRS_OP_INTR) begin
					mpc = t[2] ? `PRS_VEC_HIGH : `PRS_VEC_LOW;
					msh = r[23:0];
				end else if (o != prs_pkg::PRS_OP_PUSH) begin
					mpc = {t[20:1], 1'b0};
				end
			end
		endcase
		if (mflt) begin
			mpc = 21'h0_0000;
			mp = 5'h00;
		end
		@(posedge aclk);
		cmd.valid <= 1'b0;
		#1;
		chk("prog_addr", mpc, prog_addr);
		chk("fault", mflt, stack_fault_reset);
		if (o == prs_pkg::PRS_OP_RETURN_FROM_INTERRUPT && t[3]) chk("restore", msh, restore_regs);
		if (mflt) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog.
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	initial begin
		#100000;
		num_errors++;
		complete_run;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{num_errors, check_count, seed} = {32'h0, 32'h0, 32'h0000_f3a0};
		{aresetn, core_reset, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata, cmd, live_regs, msh} = '0;
		{mp, mpc, mfull, munf, men, mlu, mlh} = {5'h00, 21'h0_0000, 3'b001, 5'h00, 8'h00};
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i <= 36; i += 4) reg_r(i[7:0]);
		reg_r(8'h02);
		reg_w(`PRS_ADDR_CONFIG, 8'h00);
		// Fill past the depth with the fault reset off, then unwind one too far.
		for (i = 0; i < 33; i++) begin
			op(i[0] ? prs_pkg::PRS_OP_CALL : prs_pkg::PRS_OP_RELATIVE_CALL, rnd());
			reg_r(`PRS_ADDR_TOS_LO);
			op(prs_pkg::PRS_OP_SEQ, 21'h0_0000);
		end
		reg_r(`PRS_ADDR_RETURN_STACK_POINTER_STATUS);
		reg_r(`PRS_ADDR_TOS_UP);
		for (i = 0; i < 32; i++) op(i[0] ? prs_pkg::PRS_OP_RETURN : prs_pkg::PRS_OP_RETURN_WITH_LITERAL, 21'h0_0000);
		reg_r(`PRS_ADDR_RETURN_STACK_POINTER_STATUS);
		reg_w(`PRS_ADDR_RETURN_STACK_POINTER_STATUS, 8'h00);
		reg_r(`PRS_ADDR_RETURN_STACK_POINTER_STATUS);
		// Latches feed the low byte write; calls leave them, low byte reads refill them.
		reg_w(`PRS_ADDR_LAT_HI, 8'(rnd() >> 3));
		reg_w(`PRS_ADDR_LAT_UP, 8'hff);
		op(prs_pkg::PRS_OP_CALL, rnd());
		reg_r(`PRS_ADDR_LAT_HI);
		reg_r(`PRS_ADDR_LAT_UP);
		reg_w(`PRS_ADDR_PC_LO, 8'h35);
		chk("prog_addr", mpc, prog_addr);
		op(prs_pkg::PRS_OP_GOTO, rnd());
		reg_r(`PRS_ADDR_PC_LO);
		reg_r(`PRS_ADDR_LAT_HI);
		reg_r(`PRS_ADDR_LAT_UP);
		op(prs_pkg::PRS_OP_BRANCH, rnd());
		// Software stack edit with interrupts held off.
		op(prs_pkg::PRS_OP_PUSH, 21'h0_0000);
		reg_r(`PRS_ADDR_TOS_LO);
		reg_w(`PRS_ADDR_TOS_UP, 8'h01);
		reg_w(`PRS_ADDR_TOS_HI, 8'h23);
		reg_w(`PRS_ADDR_TOS_LO, 8'h46);
		op(prs_pkg::PRS_OP_RETURN, 21'h0_0000);
		op(prs_pkg::PRS_OP_PUSH, 21'h0_0000);
		op(prs_pkg::PRS_OP_PUSH, 21'h0_0000);
		op(prs_pkg::PRS_OP_POP, 21'h0_0000);
		reg_r(`PRS_ADDR_RETURN_STACK_POINTER_STATUS);
		reg_r(`PRS_ADDR_TOS_LO);
		reg_w(`PRS_ADDR_RETURN_STACK_POINTER_STATUS, 8'h05);
		op(prs_pkg::PRS_OP_CALL, rnd());
		reg_r(`PRS_ADDR_TOS_HI);
		// Both interrupt levels; the fast return brings the shadow back.
		op(prs_pkg::PRS_OP_INTR, 21'h0_0004);
		op(prs_pkg::PRS_OP_RETURN_FROM_INTERRUPT, 21'h0_0008);
		op(prs_pkg::PRS_OP_INTR, 21'h0_0000);
		op(prs_pkg::PRS_OP_RETURN_FROM_INTERRUPT, 21'h0_0000);
		// Fault reset on: overflow on the 31st push, then an underflow.
		reg_w(`PRS_ADDR_CONFIG, 8'h01);
		reg_w(`PRS_ADDR_RETURN_STACK_POINTER_STATUS, 8'h1d);
		op(prs_pkg::PRS_OP_PUSH, 21'h0_0000);
		op(prs_pkg::PRS_OP_PUSH, 21'h0_0000);
		reg_r(`PRS_ADDR_RETURN_STACK_POINTER_STATUS);
		reg_w(`PRS_ADDR_RETURN_STACK_POINTER_STATUS, 8'h9f);
		reg_r(`PRS_ADDR_TOS_LO);
		reg_w(`PRS_ADDR_RETURN_STACK_POINTER_STATUS, 8'h80);
		op(prs_pkg::PRS_OP_RETURN, 21'h0_0000);
		// Core reset clears counter and pointer but keeps the flags.
		op(prs_pkg::PRS_OP_CALL, rnd());
		@(posedge aclk);
		core_reset <= 1'b1;
		@(posedge aclk);
		core_reset <= 1'b0;
		{mpc, mp} = {21'h0_0000, 5'h00};
		#1;
		chk("prog_addr", mpc, prog_addr);
		reg_r(`PRS_ADDR_RETURN_STACK_POINTER_STATUS);
		// A second power-on reset clears the flags.
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		{mp, mpc, mfull, munf, men, mlu, mlh} = {5'h00, 21'h0_0000, 3'b001, 5'h00, 8'h00};
		reg_r(`PRS_ADDR_RETURN_STACK_POINTER_STATUS);
		reg_r(`PRS_ADDR_CONFIG);
		complete_run;
	end
endmodule
